// File: pkg/edge_if.sv
/*
  Carrier between the top and the pin edge detector.
  Assumes pins are already synchronised to clk_i.
*/
`timescale 1ns/1ps
interface edge_if #(parameter int W = 8);
  logic [W-1:0] pins;
  logic [W-1:0] rise_sel;
  logic [W-1:0] enable;
  logic hit;
  modport det (input pins, input rise_sel, input enable, output hit);
  modport top (output pins, output rise_sel, output enable, input hit);
endinterface : edge_if

// File: pkg/irq_pkg.sv
/*
  Constants shared by the timer and interrupt source block.
  Assumes a single 250 MHz clock; the 1 MHz time base is derived from it.
*/
// How it works
// (RULE_01) free-running 12-bit counter ticks once per microsecond from 1 MHz base
// (RULE_02) timer gives two sources: 128 us period and 1.024 ms period
// (RULE_03) reading the low timer byte captures the upper nibble into a hidden latch
// (RULE_04) reading the upper nibble returns the hidden latch, not the live counter
// (RULE_05) eleven sources, each separately maskable, each with its own vector
// (RULE_06) sources: bus reset, timer bit 6, timer bit 9, five endpoints, sink, gpio, i2c
// (RULE_07) timer taps request only on a zero-to-one change of the bit
// (RULE_08) endpoint requests on host data written and on packet sent
// (RULE_09) sink port has a per-pin enable mask plus the source enable
// (RULE_10) gpio ports have a per-pin enable mask
// (RULE_11) all enabled gpio pin events merge into one shared-vector request
// (RULE_12) sink port edge polarity is set per pin
// (RULE_13) gpio edge polarity comes from each port's configuration setting
// (RULE_14) polarity selects rising (0 to 1) or falling (1 to 0) edge
// (RULE_15) simultaneous pending requests resolve by fixed priority, one vector at a time
package irq_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_MHZ = 1;
  localparam int TICK_DIV = CLK_MHZ / TICK_MHZ;
  localparam int TIMER_W = 12;
  localparam int TAP_FAST = 6;
  localparam int TAP_SLOW = 9;

  // ==========================================================
  // sources, listed in priority order, highest first
  localparam int NUM_SRC = 11;
  localparam int VEC_W = 4;
  localparam int SRC_BUS_RESET = 0;
  localparam int SRC_TMR_FAST = 1;
  localparam int SRC_TMR_SLOW = 2;
  localparam int SRC_EP0 = 3;
  localparam int NUM_EP = 5;
  localparam int SRC_SINK = 8;
  localparam int SRC_GPIO = 9;
  localparam int SRC_I2C = 10;

  // ==========================================================
  // reset values
  localparam logic [11:0] TIMER_RST = 12'h000;
  localparam logic [3:0] HOLD_RST = 4'h0;
  localparam logic [3:0] VEC_RST = 4'h0;

endpackage : irq_pkg

// File: rtl/pin_edge_det.sv
/*
  Per-pin edge detector with per-pin polarity and enable mask; ORs all hits.
  Assumes synchronised pins and the reset copy of the top.
*/
`timescale 1ns/1ps
module pin_edge_det #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  edge_if.det port
);
  logic [W-1:0] prev_q;
  logic [W-1:0] ev;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= port.pins;
    end
  end

  // ==========================================================
  // edge select per pin
  genvar g;
  for (g = 0; g < W; g++) begin : g_pin
    assign ev[g] = port.enable[g] & (port.rise_sel[g] ?
                   (port.pins[g] & ~prev_q[g]) : (~port.pins[g] & prev_q[g])); // RULE_14
  end

  assign port.hit = |ev;
endmodule : pin_edge_det

// File: rtl/timer_irq_ctrl.sv
/*
  12-bit microsecond timer with coherent read latch and an eleven-source
  vectored interrupt controller.
  Assumes pin inputs are asynchronous, other event inputs come from clk_i logic,
  and the core acknowledges one vector at a time with irq_ack_i.
*/
`timescale 1ns/1ps
module timer_irq_ctrl #(
  parameter int SINK_W = 4,
  parameter int GPIO_PORTS = 4,
  parameter int GPIO_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_timer_lo_i,
  input wire logic rd_timer_hi_i,
  output logic [7:0] timer_lo_o,
  output logic [3:0] timer_hi_o,
  input wire logic [irq_pkg::NUM_SRC-1:0] src_en_i,
  input wire logic bus_reset_i,
  input wire logic [irq_pkg::NUM_EP-1:0] ep_rx_done_i,
  input wire logic [irq_pkg::NUM_EP-1:0] ep_tx_done_i,
  input wire logic i2c_event_i,
  input wire logic [SINK_W-1:0] sink_pins_i,
  input wire logic [SINK_W-1:0] sink_pin_en_i,
  input wire logic [SINK_W-1:0] sink_rise_i,
  input wire logic [GPIO_PORTS*GPIO_W-1:0] gpio_pins_i,
  input wire logic [GPIO_PORTS*GPIO_W-1:0] gpio_pin_en_i,
  input wire logic [GPIO_PORTS-1:0] gpio_port_rise_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  output logic [irq_pkg::VEC_W-1:0] irq_vec_o,
  output logic [irq_pkg::NUM_SRC-1:0] pending_o
);
  localparam int GW = GPIO_PORTS * GPIO_W;

  initial begin
    if (SINK_W < 1 || GPIO_PORTS < 1 || GPIO_W < 1) begin
      $error("pin widths must be at least one");
    end
  end

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [SINK_W-1:0] sink_meta_q;
  logic [SINK_W-1:0] sink_sync_q;
  logic [GW-1:0] gpio_meta_q;
  logic [GW-1:0] gpio_sync_q;
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sink_meta_q <= '0;
      sink_sync_q <= '0;
      gpio_meta_q <= '0;
      gpio_sync_q <= '0;
    end else begin
      sink_meta_q <= sink_pins_i;
      sink_sync_q <= sink_meta_q;
      gpio_meta_q <= gpio_pins_i;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // ==========================================================
  // microsecond time base and free-running counter
  logic [7:0] div_q;
  logic [irq_pkg::TIMER_W-1:0] timer_q;
  logic tick;
  assign tick = (div_q == 8'(irq_pkg::TICK_DIV - 1));

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      timer_q <= irq_pkg::TIMER_RST;
    end else if (tick) begin
      timer_q <= timer_q + 12'h001; // RULE_01
    end
  end

  // ==========================================================
  // coherent read: low byte read snapshots the nibble
  logic [3:0] hold_q;
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hold_q <= irq_pkg::HOLD_RST;
      timer_lo_o <= 8'h00;
      timer_hi_o <= 4'h0;
    end else begin
      if (rd_timer_lo_i) begin
        timer_lo_o <= timer_q[7:0];
        hold_q <= timer_q[11:8]; // RULE_03
      end
      if (rd_timer_hi_i) begin
        // a same-cycle low read shows the nibble being captured now
        timer_hi_o <= rd_timer_lo_i ? timer_q[11:8] : hold_q; // RULE_04
      end
    end
  end

  // ==========================================================
  // timer taps: rising edge only
  logic fast_prev_q;
  logic slow_prev_q;
  logic fast_ev;
  logic slow_ev;
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      fast_prev_q <= timer_q[irq_pkg::TAP_FAST];
      slow_prev_q <= timer_q[irq_pkg::TAP_SLOW];
    end
  end
  assign fast_ev = timer_q[irq_pkg::TAP_FAST] & ~fast_prev_q; // RULE_02 RULE_07
  assign slow_ev = timer_q[irq_pkg::TAP_SLOW] & ~slow_prev_q; // RULE_02 RULE_07

  // ==========================================================
  // pin sources
  edge_if #(.W(SINK_W)) sink_port ();
  edge_if #(.W(GW)) gpio_port ();
  assign sink_port.pins = sink_sync_q;
  assign sink_port.enable = sink_pin_en_i; // RULE_09
  assign sink_port.rise_sel = sink_rise_i; // RULE_12
  assign gpio_port.pins = gpio_sync_q;
  assign gpio_port.enable = gpio_pin_en_i; // RULE_10

  genvar p;
  for (p = 0; p < GPIO_PORTS; p++) begin : g_port
    assign gpio_port.rise_sel[p*GPIO_W +: GPIO_W] = {GPIO_W{gpio_port_rise_i[p]}}; // RULE_13
  end

  pin_edge_det #(.W(SINK_W)) u_sink (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_q),
    .port(sink_port.det)
  );
  // one detector over all ports: every gpio event lands on one vector
  pin_edge_det #(.W(GW)) u_gpio (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_q),
    .port(gpio_port.det) // RULE_11
  );

  // ==========================================================
  // source collection
  logic [irq_pkg::NUM_SRC-1:0] ev;
  always_comb begin
    ev = '0;
    ev[irq_pkg::SRC_BUS_RESET] = bus_reset_i;
    ev[irq_pkg::SRC_TMR_FAST] = fast_ev;
    ev[irq_pkg::SRC_TMR_SLOW] = slow_ev;
    ev[irq_pkg::SRC_EP0 +: irq_pkg::NUM_EP] = ep_rx_done_i | ep_tx_done_i; // RULE_08
    ev[irq_pkg::SRC_SINK] = sink_port.hit;
    ev[irq_pkg::SRC_GPIO] = gpio_port.hit;
    ev[irq_pkg::SRC_I2C] = i2c_event_i; // RULE_06
  end

  // ==========================================================
  // pending latches and fixed-priority dispatch
  logic [irq_pkg::NUM_SRC-1:0] pend_q;
  logic [irq_pkg::NUM_SRC-1:0] clr;
  logic [irq_pkg::NUM_SRC-1:0] live;
  logic [irq_pkg::VEC_W-1:0] win;
  logic any;

  // the source being acknowledged now must not win the next round again
  assign live = pend_q & ~clr & src_en_i;

  always_comb begin
    win = irq_pkg::VEC_RST;
    any = 1'b0;
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        win = irq_pkg::VEC_W'(i); // RULE_15
        any = 1'b1;
      end
    end
  end

  always_comb begin
    clr = '0;
    if (irq_ack_i && irq_req_o) begin
      clr[irq_vec_o] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pend_q <= '0;
    end else begin
      // set beats the acknowledge clear
      pend_q <= ((pend_q & ~clr) | ev) & src_en_i; // RULE_05
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_req_o <= 1'b0;
      irq_vec_o <= irq_pkg::VEC_RST;
      pending_o <= '0;
    end else begin
      // hold the vector while it waits; re-arbitrate after the ack or once its source is masked
      if (!irq_req_o || irq_ack_i || !src_en_i[irq_vec_o]) begin
        irq_req_o <= any;
        irq_vec_o <= win;
      end
      pending_o <= pend_q;
    end
  end
endmodule : timer_irq_ctrl

// File: verification/core_model.sv
/* processor core model: takes vectors one at a time.
   assumes registered irq_req_i/irq_vec_i. */
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic irq_req_i,
  input wire logic [3:0] irq_vec_i,
  input wire logic slow_i,
  output logic irq_ack_o
);
  // ==========
  // ack with optional random stall
  logic [1:0] wait_q;
  logic [3:0] got_q[$];
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ack_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (irq_ack_o) begin
      // idle one edge so the next vector is the refreshed one
      irq_ack_o <= 1'b0;
      wait_q <= slow_i ? 2'($urandom) : 2'h0;
    end else if (irq_req_i && wait_q == 2'h0) begin
      irq_ack_o <= 1'b1;
      got_q.push_back(irq_vec_i);
    end else if (irq_req_i) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule : core_model

// File: verification/timer_irq_ctrl_assertions.sv
/* port checker for timer_irq_ctrl.
   assumes one clock and active-low reset. */
`timescale 1ns/1ps
module timer_irq_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_timer_lo_i,
  input wire logic rd_timer_hi_i,
  input wire logic [7:0] timer_lo_o,
  input wire logic [3:0] timer_hi_o,
  input wire logic [10:0] src_en_i,
  input wire logic bus_reset_i,
  input wire logic irq_ack_i,
  input wire logic irq_req_o,
  input wire logic [3:0] irq_vec_o,
  input wire logic [10:0] pending_o
);
  // ==========
  // relations
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_vec_in_range: assert property (irq_req_o |-> irq_vec_o < 4'hB)
    else $error("vector out of range");
  a_vec_held: assert property (irq_req_o && !irq_ack_i && src_en_i[irq_vec_o]
    |=> irq_req_o && $stable(irq_vec_o)) else $error("vector changed before ack");
  a_lo_held: assert property (!rd_timer_lo_i |=> $stable(timer_lo_o))
    else $error("low byte moved without read");
  a_hi_held: assert property (!rd_timer_hi_i |=> $stable(timer_hi_o))
    else $error("nibble moved without read");
  a_bus_reset_req: assert property (bus_reset_i && src_en_i[0] |-> ##[1:3] irq_req_o)
    else $error("bus reset not requested");
  a_masked_quiet: assert property ((src_en_i == 11'h000) [*4] |-> !irq_req_o)
    else $error("request while all masked");
  a_pend_backs_req: assert property (irq_req_o |-> ##[0:1] pending_o[irq_vec_o])
    else $error("request without pending");
  a_reset_clears: assert property (disable iff (1'b0) !rst_n_i |-> !irq_req_o)
    else $error("request during reset");
endmodule : timer_irq_ctrl_assertions
bind timer_irq_ctrl timer_irq_ctrl_assertions u_chk (.clk_i, .rst_n_i, .rd_timer_lo_i,
  .rd_timer_hi_i, .timer_lo_o, .timer_hi_o, .src_en_i, .bus_reset_i, .irq_ack_i,
  .irq_req_o, .irq_vec_o, .pending_o);

// File: verification/timer_irq_ctrl_tb_top.sv
/* self-checking bench for timer_irq_ctrl.
   assumes core_model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module timer_irq_ctrl_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic rd_lo = 1'b0;
  logic rd_hi = 1'b0;
  logic bus_rst = 1'b0;
  logic i2c = 1'b0;
  logic slow = 1'b0;
  logic [4:0] ep_rx = 5'h00;
  logic [4:0] ep_tx = 5'h00;
  logic [10:0] src_en = 11'h000;
  logic [3:0] sink = 4'h0;
  logic [3:0] sink_en = 4'h0;
  logic [3:0] sink_rise = 4'h0;
  logic [3:0] gpio_rise = 4'h0;
  logic [31:0] gpio = 32'h00000000;
  logic [31:0] gpio_en = 32'h00000000;
  logic [7:0] lo;
  logic [3:0] hi;
  logic ack;
  logic req;
  logic [3:0] vec;
  logic [10:0] pend;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [3:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int k;
  int j;
  timer_irq_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_timer_lo_i(rd_lo),
    .rd_timer_hi_i(rd_hi), .timer_lo_o(lo), .timer_hi_o(hi), .src_en_i(src_en),
    .bus_reset_i(bus_rst), .ep_rx_done_i(ep_rx), .ep_tx_done_i(ep_tx), .i2c_event_i(i2c),
    .sink_pins_i(sink), .sink_pin_en_i(sink_en), .sink_rise_i(sink_rise),
    .gpio_pins_i(gpio), .gpio_pin_en_i(gpio_en), .gpio_port_rise_i(gpio_rise),
    .irq_ack_i(ack), .irq_req_o(req), .irq_vec_o(vec), .pending_o(pend));
  core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_req_i(req), .irq_vec_i(vec),
    .slow_i(slow), .irq_ack_o(ack));
  always #2 clk_i = ~clk_i;
  // ==========
  // helpers
  function automatic logic pin_hit(logic en, logic rise, logic newv);
    return en && (rise == newv);
  endfunction : pin_hit
  task automatic rd(input bit sel_hi, output logic [7:0] v);
    @(posedge clk_i);
    if (sel_hi) rd_hi <= 1'b1;
    else rd_lo <= 1'b1;
    @(posedge clk_i);
    rd_lo <= 1'b0;
    rd_hi <= 1'b0;
    @(negedge clk_i);
    v = sel_hi ? {4'h0, hi} : lo;
  endtask : rd
  task automatic drain;
    // worst case: seven vectors with a three-cycle core stall each
    repeat (48) @(posedge clk_i);
    `CHK(u_core.got_q.size(), exp_q.size())
    `CHK(pend, 11'h000)
    foreach (exp_q[n]) `CHK(u_core.got_q[n], exp_q[n])
    exp_q.delete();
    u_core.got_q.delete();
  endtask : drain
  task automatic end_of_test;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // budget: about 70k cycles of tests
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========
  // sequence
  initial begin
    // a real falling edge, so the asynchronous resets act before the first clock
    rst_n_i <= 1'b0;
    void'($urandom(83));
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    src_en <= 11'h7FF;
    slow <= 1'b1;
    @(posedge clk_i);
    bus_rst <= 1'b1;
    ep_rx <= 5'h1F;
    i2c <= 1'b1;
    @(posedge clk_i);
    {bus_rst, ep_rx, i2c} <= 7'h00;
    exp_q = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA};
    drain();
    for (int i = 0; i < 40; i++) begin
      k = $urandom % 6;
      @(posedge clk_i);
      {src_en, sink_en, sink_rise, gpio_rise, slow} <= 24'($urandom);
      gpio_en <= $urandom;
      @(posedge clk_i);
      case (k)
        0: begin bus_rst <= 1'b1; if (src_en[0]) exp_q.push_back(4'h0); end
        1, 2: begin
          j = $urandom % 5;
          if (k == 1) ep_rx[j] <= 1'b1;
          else ep_tx[j] <= 1'b1;
          if (src_en[3+j]) exp_q.push_back(4'(3 + j));
        end
        3: begin i2c <= 1'b1; if (src_en[10]) exp_q.push_back(4'hA); end
        4: begin
          j = $urandom % 4;
          sink[j] <= ~sink[j];
          if (src_en[8] && pin_hit(sink_en[j], sink_rise[j], ~sink[j]))
            exp_q.push_back(4'h8);
        end
        default: begin
          j = $urandom % 32;
          gpio[j] <= ~gpio[j];
          if (src_en[9] && pin_hit(gpio_en[j], gpio_rise[j/8], ~gpio[j]))
            exp_q.push_back(4'h9);
        end
      endcase
      @(posedge clk_i);
      {bus_rst, ep_rx, ep_tx, i2c} <= 12'h000;
      drain();
    end
    // every source masked: events are dropped and no request appears
    src_en <= 11'h000;
    bus_rst <= 1'b1;
    i2c <= 1'b1;
    @(posedge clk_i);
    {bus_rst, i2c} <= 2'h0;
    drain();
    src_en <= 11'h002;
    slow <= 1'b0;
    rd(1'b0, v0);
    repeat (748) @(posedge clk_i);
    rd(1'b0, v1);
    `CHK(v1, v0 + 8'h03)
    rd(1'b1, v0);
    `CHK(v0, 8'h00)
    // counter passes 256; only the two 0-to-1 changes of bit 6 request
    repeat (65000) @(posedge clk_i);
    rd(1'b1, v0);
    `CHK(v0, 8'h00)
    rd(1'b0, v1);
    rd(1'b1, v0);
    `CHK(v0, 8'h01)
    exp_q = '{4'h1, 4'h1};
    drain();
    end_of_test();
  end
endmodule : timer_irq_ctrl_tb_top
